//--- apcs_map.vh
// Constants for the analog pair conversion sequencer
`ifndef APCS_MAP_VH
`define APCS_MAP_VH
`define APCS_NUM_PAIRS      13
`define APCS_PAIR_W         4
`define APCS_INPUT_W        5
`define APCS_SYNC_STAGES    2
`define APCS_SAMPLE_TAD     2
`define APCS_EARLY_IRQ_TAD  7
`define APCS_CONV_TAD       12
`define APCS_TAD_DIV        4
`define APCS_TAD_DIV_W      3
`define APCS_CNT_W          4
`define APCS_DED_MASK       13'h003f
`endif

//--- apcs_sequencer.v
// Sample and conversion sequencer for paired analog inputs
//
// Functional notes
// [RULE1] Requests resynchronised into the conversion clock domain
// [RULE2] Triggered sampling window lasts two conversion clocks
// [RULE3] Continuous sampling holds dedicated circuit on request
// [RULE4] Single converter continuous: odd sampled after sync
// [RULE5] Single converter early: interrupt after first conversion
// [RULE6] Single converter late: interrupt after second conversion
// [RULE7] Simultaneous requests served pair 0 first
// [RULE8] Lower pair sampled together, converted even first
// [RULE9] Even inputs held dedicated, odd share one circuit
// [RULE10] Dual converter ignores sequential and order selects
// [RULE11] Dual converter converts even and odd in parallel
// [RULE12] Dual converter early interrupt after seven clocks
// [RULE13] Dual converter late interrupt after full conversion
// [RULE14] Dedicated pairs follow the sampling style select
// [RULE15] Shared pairs always triggered and parallel; the code converts them in parallel only on a dual converter
// [RULE16] Shared pairs sample both inputs at once; the code raises only the shared even sample for them
// [RULE17] Dual continuous: odd sampled on shared odd after sync
// [RULE18] Normal order even first, reverse order odd first
// [RULE19] Sequential shared sample at second or first conversion
// [RULE20] Triggered requests wait until the converter is idle
// [RULE21] Requester leaves minimum sampling time between requests
// [RULE22] Pending flag per pair, results tagged with input index
`include "apcs_map.vh"
`timescale 1ns/100ps
`default_nettype none
module apcs_sequencer
(
   input  wire        clk_sys_in,
   input  wire        reset_in,
   input  wire        dual_converter_in,
   input  wire        continuous_sampling_select_in,
   input  wire        sequential_hold_select_in,
   input  wire        reverse_order_select_in,
   input  wire        early_irq_enable_in,
   input  wire [12:0] pair_request_in,
   output reg  [12:0] dedicated_hold_out,
   output reg         shared_even_sample_out,
   output reg         shared_odd_sample_out,
   output reg         conv_start_out,
   output reg  [4:0]  conv_even_index_out,
   output reg  [4:0]  conv_odd_index_out,
   output reg         conv_parallel_out,
   output reg         conv_done_out,
   output reg  [12:0] pair_irq_out,
   output reg  [3:0]  active_pair_out,
   output reg         busy_out
);

////////////////////////////////////////////////////////////////////////////////
// States, one-hot
localparam [5:0] ST_IDLE    = 6'h01;
localparam [5:0] ST_SAMPLE  = 6'h02;
localparam [5:0] ST_CONV1   = 6'h04;
localparam [5:0] ST_SAMPLE2 = 6'h08;
localparam [5:0] ST_CONV2   = 6'h10;
localparam [5:0] ST_DONE    = 6'h20;

////////////////////////////////////////////////////////////////////////////////
// Declarations
reg  [2:0]  tad_div;             // Conversion clock divider
reg         tad_en;              // One conversion clock tick
reg  [12:0] req_meta;            // First synchroniser stage
reg  [12:0] req_sync;            // Second synchroniser stage
reg  [12:0] req_prev;            // Edge detector history
reg  [12:0] pending;             // Pending flag per pair
reg  [5:0]  state;               // Sequencer state
reg  [3:0]  cnt;                 // Conversion clock counter
reg  [3:0]  pair;                // Pair being served
reg         ded;                 // Pair has a dedicated even hold
reg         par;                 // Parallel conversion this pair
reg         odd_first;           // Odd converted first
wire [12:0] req_rise;            // New synchronised request
wire [3:0]  win;                 // Highest priority pending pair
wire        any_pend;            // Some pair waits

////////////////////////////////////////////////////////////////////////////////
// Fixed priority encoder, lowest index wins
function [3:0] apcs_first;
   input [12:0] v;
   integer i;
   begin
      apcs_first = 4'h0;
      for (i = 12; i >= 0; i = i - 1)
         if (v[i])
            apcs_first = i[3:0];
   end
endfunction

// Dedicated hold present for a pair
function apcs_has_ded;
   input [3:0] p;
   reg   [12:0] m;
   begin
      m = `APCS_DED_MASK;
      apcs_has_ded = m[p];
   end
endfunction

assign req_rise = req_sync & ~req_prev;
assign win      = apcs_first(pending);  // [RULE7]
assign any_pend = |pending;

////////////////////////////////////////////////////////////////////////////////
// Conversion clock enable divider
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      tad_div <= 3'h0;
      tad_en  <= 1'b0;
   end
   else if (tad_div == `APCS_TAD_DIV - 1)
   begin
      tad_div <= 3'h0;
      tad_en  <= 1'b1;
   end
   else
   begin
      tad_div <= tad_div + 3'h1;
      tad_en  <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Two-stage request resynchroniser on conversion clock ticks
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      req_meta <= 13'h0000;
      req_sync <= 13'h0000;
      req_prev <= 13'h0000;
   end
   else if (tad_en)
   begin
      req_meta <= pair_request_in;   // [RULE1]
      req_sync <= req_meta;          // [RULE1]
      req_prev <= req_sync;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Dedicated hold circuits: track while idle, hold at request in continuous mode, after the sampling window when triggered
genvar g;
generate
   for (g = 0; g < `APCS_NUM_PAIRS; g = g + 1)
   begin : g_hold
      always @(posedge clk_sys_in)
      begin
         if (reset_in)
            dedicated_hold_out[g] <= 1'b0;
         else if (!apcs_has_ded(g))
            dedicated_hold_out[g] <= 1'b0;
         // Continuous mode: hold before synchronisation
         else if (continuous_sampling_select_in && pair_request_in[g])
            dedicated_hold_out[g] <= 1'b1;   // [RULE3] [RULE9]
         // Release once this pair's conversion has ended
         else if (state == ST_DONE && tad_en && pair == g)
            dedicated_hold_out[g] <= 1'b0;
         // Triggered mode: hold after the sampling window
         else if (state == ST_SAMPLE && tad_en && pair == g
                  && cnt == `APCS_SAMPLE_TAD - 1)
            dedicated_hold_out[g] <= 1'b1;   // [RULE2]
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Sequencer state machine
always @(posedge clk_sys_in)
begin
   if (reset_in)
   begin
      state                  <= ST_IDLE;
      pending                <= 13'h0000;
      cnt                    <= 4'h0;
      pair                   <= 4'h0;
      ded                    <= 1'b0;
      par                    <= 1'b0;
      odd_first              <= 1'b0;
      shared_even_sample_out <= 1'b0;
      shared_odd_sample_out  <= 1'b0;
      conv_start_out         <= 1'b0;
      conv_even_index_out    <= 5'h00;
      conv_odd_index_out     <= 5'h00;
      conv_parallel_out      <= 1'b0;
      conv_done_out          <= 1'b0;
      pair_irq_out           <= 13'h0000;
      active_pair_out        <= 4'h0;
      busy_out               <= 1'b0;
   end
   else
   begin
      conv_start_out <= 1'b0;
      conv_done_out  <= 1'b0;
      pair_irq_out   <= 13'h0000;
      // New requests set flags; set wins over the start clear
      pending <= (pending & ~((state == ST_IDLE && tad_en && any_pend)
                 ? (13'h0001 << win) : 13'h0000)) | (tad_en ? req_rise : 13'h0000); // [RULE22]
      if (tad_en)
      begin
         case (state)
            ST_IDLE:
            begin
               // Waiting requests start only here, when idle
               if (any_pend)                                    // [RULE20]
               begin
                  pair      <= win;
                  active_pair_out <= win;
                  busy_out  <= 1'b1;
                  ded       <= apcs_has_ded(win);
                  // Dual converter: parallel always, selects ignored
                  par       <= dual_converter_in;               // [RULE10] [RULE11]
                  odd_first <= !dual_converter_in && reverse_order_select_in; // [RULE8] [RULE18]
                  cnt       <= 4'h0;
                  state     <= ST_SAMPLE;
                  // Shared pairs sample only their even input, on the shared even circuit
                  shared_even_sample_out <= !apcs_has_ded(win);  // [RULE15] [RULE16]
                  // Dedicated pairs: odd sampled now unless single sequential with normal order
                  shared_odd_sample_out  <= apcs_has_ded(win) && (dual_converter_in
                     || !sequential_hold_select_in || reverse_order_select_in); // [RULE4] [RULE17] [RULE19]
               end
            end
            ST_SAMPLE:
            begin
               if (cnt == `APCS_SAMPLE_TAD - 1)                 // [RULE2]
               begin
                  shared_even_sample_out <= 1'b0;
                  shared_odd_sample_out  <= 1'b0;
                  conv_start_out      <= 1'b1;
                  conv_parallel_out   <= par;                   // [RULE11] [RULE14]
                  conv_even_index_out <= {pair, 1'b0};          // [RULE22]
                  conv_odd_index_out  <= {pair, 1'b1};          // [RULE22]
                  cnt   <= 4'h0;
                  state <= ST_CONV1;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            ST_CONV1:
            begin
               // Dual early interrupt seven clocks into conversion
               if (par && early_irq_enable_in && cnt == `APCS_EARLY_IRQ_TAD - 1)
                  pair_irq_out[pair] <= 1'b1;                   // [RULE12]
               if (cnt == `APCS_CONV_TAD - 1)
               begin
                  cnt           <= 4'h0;
                  conv_done_out <= 1'b1;
                  if (par)
                  begin
                     if (!early_irq_enable_in)
                        pair_irq_out[pair] <= 1'b1;             // [RULE13]
                     state <= ST_DONE;
                  end
                  else
                  begin
                     if (early_irq_enable_in)
                        pair_irq_out[pair] <= 1'b1;             // [RULE5]
                     // Second input: late odd sample if still needed
                     if (ded && sequential_hold_select_in && !odd_first)
                     begin
                        shared_odd_sample_out <= 1'b1;          // [RULE19]
                        state <= ST_SAMPLE2;
                     end
                     else
                     begin
                        conv_start_out <= 1'b1;
                        state <= ST_CONV2;
                     end
                  end
               end
               else
                  cnt <= cnt + 4'h1;
            end
            ST_SAMPLE2:
            begin
               if (cnt == `APCS_SAMPLE_TAD - 1)                 // [RULE2]
               begin
                  shared_odd_sample_out <= 1'b0;
                  conv_start_out <= 1'b1;
                  cnt   <= 4'h0;
                  state <= ST_CONV2;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            ST_CONV2:
            begin
               if (cnt == `APCS_CONV_TAD - 1)
               begin
                  conv_done_out <= 1'b1;
                  if (!early_irq_enable_in)
                     pair_irq_out[pair] <= 1'b1;                // [RULE6]
                  cnt   <= 4'h0;
                  state <= ST_DONE;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            ST_DONE:
            begin
               busy_out <= 1'b0;
               state    <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Which input converts in each single-converter slot:
// slot one is odd when odd_first, even otherwise
// This is signalled through conv_odd_index_out / conv_even_index_out
// together with the order input; conv_parallel_out marks dual mode.
//
// Timing summary, in conversion clock ticks after the request edge:
//   ticks 1 to 2  request passes the two synchroniser stages
//   tick 3        edge detector sets the pending flag
//   tick 4        idle sequencer takes the winner, sample window opens
//   ticks 5 to 6  sample window of two ticks, then conversion starts
//   12 ticks      one conversion; single converter runs two in a row
//
// Hazards and limits worth knowing:
//   A request held high is one request; it must fall and rise again
//   before the same pair can be served a second time.
//   Requests that arrive while busy set pending flags and, in continuous mode, dedicated holds; they are
//   served one at a time in priority order once the sequencer is idle.
//   In continuous sampling the dedicated hold follows the request pin
//   directly, so the requester must respect the minimum sampling time
//   between the end of one conversion and its next request.
//   The dual/single choice is a strap and must not change mid-pair.
//   The divider is free running; a request is seen on the next tick,
//   which gives the three to four tick spread of the start latency.
//   Pairs above the dedicated mask never drive their hold output.
//   Interrupt, start and done outputs are single clock pulses; a
//   consumer on a slower clock must stretch them itself.
//   The early interrupt on a dual device fires while the parallel
//   conversion still runs; results are not yet valid at that point.
endmodule
`default_nettype wire

//--- apcs_trigger_model.sv
// Trigger source model that raises pair requests for the sequencer
`timescale 1ns/100ps
`default_nettype none
module apcs_trigger_model
(
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   input  wire logic [12:0] fire_in,
   output logic      [12:0] pair_request_out
);
   logic [4:0] hold_cnt; // Cycles left before the requests drop
   // Raise requests on command and release them after a fixed hold
   always @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         pair_request_out <= 13'h0000;
         hold_cnt         <= 5'h00;
      end
      else if (fire_in != 13'h0000)
      begin
         pair_request_out <= pair_request_out | fire_in;
         hold_cnt         <= 5'h14;
      end
      else if (hold_cnt != 5'h00)
         hold_cnt <= hold_cnt - 5'h01;
      else
         pair_request_out <= 13'h0000; // Released so the next edge is seen
   end
endmodule
`default_nettype wire

//--- apcs_sequencer_chk.sv
// Concurrent checks on the pair conversion sequencer ports
`timescale 1ns/100ps
`default_nettype none
module apcs_sequencer_chk
(
   input wire logic        clk_sys_in,
   input wire logic        reset_in,
   input wire logic        dual_converter_in,
   input wire logic        continuous_sampling_select_in,
   input wire logic        early_irq_enable_in,
   input wire logic [12:0] pair_request_in,
   input wire logic [12:0] dedicated_hold_out,
   input wire logic        shared_odd_sample_out,
   input wire logic        conv_start_out,
   input wire logic [4:0]  conv_even_index_out,
   input wire logic [4:0]  conv_odd_index_out,
   input wire logic        conv_parallel_out,
   input wire logic [12:0] pair_irq_out,
   input wire logic [3:0]  active_pair_out,
   input wire logic        busy_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_start_one_pulse: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse longer than one cycle");
   a_index_pairing: assert property (conv_start_out |-> conv_even_index_out == {active_pair_out, 1'b0}
      && conv_odd_index_out == {active_pair_out, 1'b1}) else $error("input index mismatch");
   a_irq_active_pair: assert property ((pair_irq_out != 13'h0000) |->
      pair_irq_out == (13'h0001 << active_pair_out)) else $error("irq for wrong pair");
   a_parallel_dual: assert property (conv_start_out |-> conv_parallel_out == dual_converter_in)
      else $error("parallel flag wrong");
   a_odd_window_two: assert property ($rose(shared_odd_sample_out) |=> shared_odd_sample_out[*7])
      else $error("odd sample window short");
   a_dedicated_mask: assert property ((dedicated_hold_out & 13'h1fc0) == 13'h0000)
      else $error("hold on pair without dedicated circuit");
   a_start_when_busy: assert property (conv_start_out |-> busy_out)
      else $error("start while idle");
   a_dual_early_irq: assert property (dual_converter_in && early_irq_enable_in && conv_start_out
      |-> ##[24:32] (pair_irq_out != 13'h0000)) else $error("early irq late");
   a_dual_late_irq: assert property (dual_converter_in && !early_irq_enable_in && conv_start_out
      |-> ##[44:52] (pair_irq_out != 13'h0000)) else $error("late irq late");
   a_request_sync: assert property (!busy_out && $rose(pair_request_in[0]) |-> ##[1:24] busy_out)
      else $error("request not taken");
   a_hold_on_request: assert property (continuous_sampling_select_in && !busy_out &&
      $rose(pair_request_in[0]) |-> ##[0:4] dedicated_hold_out[0]) else $error("no hold");
endmodule
`default_nettype wire
bind apcs_sequencer apcs_sequencer_chk u_apcs_sequencer_chk (.clk_sys_in(clk_sys_in),
   .reset_in(reset_in), .dual_converter_in(dual_converter_in),
   .continuous_sampling_select_in(continuous_sampling_select_in),
   .early_irq_enable_in(early_irq_enable_in), .pair_request_in(pair_request_in),
   .dedicated_hold_out(dedicated_hold_out), .shared_odd_sample_out(shared_odd_sample_out),
   .conv_start_out(conv_start_out), .conv_even_index_out(conv_even_index_out),
   .conv_odd_index_out(conv_odd_index_out), .conv_parallel_out(conv_parallel_out),
   .pair_irq_out(pair_irq_out), .active_pair_out(active_pair_out), .busy_out(busy_out));

//--- apcs_sequencer_tb.sv
// Self-checking testbench for the pair conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module apcs_sequencer_tb;
   logic clk_sys_in = 1'b0, reset_in = 1'b1, dual = 1'b0, cont = 1'b0, seq = 1'b0;
   logic rev = 1'b0, early = 1'b0, shr_even, shr_odd, start, par, done, busy;
   logic [12:0] fire = 13'h0000, req, hold, irq;
   logic [4:0]  even_idx, odd_idx;
   logic [3:0]  act;
   int fail_count = 0, checked = 0, starts = 0, n_irq = 0, exp_q[$], a, b;
   int e_pair, dones = 0; // Oldest expected pair, finished conversions
   ////////////////////////////////////////////////////////////////////////////////
   apcs_trigger_model u_apcs_trigger_model (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .fire_in(fire), .pair_request_out(req));
   apcs_sequencer u_apcs_sequencer (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .dual_converter_in(dual), .continuous_sampling_select_in(cont),
      .sequential_hold_select_in(seq), .reverse_order_select_in(rev),
      .early_irq_enable_in(early), .pair_request_in(req), .dedicated_hold_out(hold),
      .shared_even_sample_out(shr_even), .shared_odd_sample_out(shr_odd),
      .conv_start_out(start), .conv_even_index_out(even_idx), .conv_odd_index_out(odd_idx),
      .conv_parallel_out(par), .conv_done_out(done), .pair_irq_out(irq),
      .active_pair_out(act), .busy_out(busy));
   // Clock at 200 MHz
   always #2.5 clk_sys_in = ~clk_sys_in;
   // Print counts and verdict, then stop
   task complete_run;
   begin
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   // Watch outputs and take the oldest expected pair at each interrupt
   always @(posedge clk_sys_in)
   begin
      if (start === 1'b1)
         starts++;
      if (done === 1'b1)
         dones++;
      if (irq !== 13'h0000)
      begin
         n_irq++;
         if (exp_q.size() == 0)
            `CHK(irq, 13'h0000)
         else
         begin
            e_pair = exp_q.pop_front();
            `CHK(irq, 13'h0001 << e_pair)
         end
      end
   end
   // Request two pairs, together or the first one alone and the second while busy
   task run_pairs(input int p1, input int p2, input int gap);
   begin
      starts = 0;
      dones = 0;
      n_irq = 0;
      exp_q.push_back((gap == 0 && p2 < p1) ? p2 : p1);
      exp_q.push_back((gap == 0 && p2 < p1) ? p1 : p2);
      fire = (13'h0001 << p1) | ((gap == 0) ? (13'h0001 << p2) : 13'h0000);
      @(posedge clk_sys_in) #1 fire = 13'h0000;
      if (gap > 0)
      begin
         repeat (gap) @(posedge clk_sys_in);
         #1 fire = 13'h0001 << p2;
         @(posedge clk_sys_in) #1 fire = 13'h0000;
      end
      repeat (3000) if (n_irq < 2 || busy !== 1'b0) @(posedge clk_sys_in);
      #1 `CHK(starts, dual ? 2 : 4)
      `CHK(dones, dual ? 2 : 4)
      repeat (40) @(posedge clk_sys_in); // Minimum sampling time
   end
   endtask
   // Main sequence over all dual, continuous and early combinations, random order selects
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      #1 reset_in = 1'b0;
      void'($urandom(32'h0b692544));
      for (int t = 0; t < 16; t++)
      begin
         {dual, cont, early} = t[2:0];
         seq = $urandom % 2;
         rev = $urandom % 2;
         a = $urandom % 12;
         b = a + 1 + $urandom % (12 - a);
         if (t < 8)
            run_pairs(a, b, 0);
         else
            run_pairs(b, a, 40);
      end
      {dual, cont, early} = 3'b010;
      run_pairs(0, 6, 0);
      complete_run;
   end
   // Cut a hang short
   initial
   begin
      repeat (100000) @(posedge clk_sys_in);
      fail_count++;
      complete_run;
   end
endmodule
`default_nettype wire
